// file: hw/gdr_bank_top.sv
/*
 * Serial slave and register bank: two sticky fault words and two
 * gate drive setup words, reached by 16-bit frames.
 * Assumes serial pins are synchronous to sys_clk_i, clock idles low,
 * data sampled on the falling edge, and each clock half period lasts
 * at least four system clocks.
 */
`default_nettype none
`include "gdr_defines.svh"

// Behaviour
// - device fault word: supply, watchdog, temperature, regulator, analog flags
// - device fault word: gate supply and charge pump flags, all reset zero
// - gate fault word bits 10..5 per transistor, bits 4..0 zero
// - control words read back bits 9:0 of the last written or default value, bit 10 reads zero
// - reads, fault clear and gate enable reset keep control words
// - power-up reset loads control word defaults
// - entering sleep restores control word defaults
// - high word bits 9:8 peak drive time, default code 3
// - low word bits 9:8 peak drive time, default code 3
// - high word bits 7:4 sink current, default 4, high codes alias
// - high word bits 3:0 source current, default 4, top codes alias
// - low word bits 7:4 sink current, same mapping as high side
// - low word bits 3:0 source current, default 4, top codes alias
// - frame: read flag bit 15, address 14:11, data 10:0
// - reply carries addressed word as before the access, low 11 bits
// - writes to status words change nothing
module gdr_bank_top (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output var logic spi_miso_o,
	output var logic spi_miso_en_n_o,
	input wire logic power_supply_undervolt_two_i,
	input wire logic watchdog_expired_flag_i,
	input wire logic overtemp_shutdown_flag_i,
	input wire logic regulator_undervolt_flag_i,
	input wire logic analog_supply_undervolt_flag_i,
	input wire logic low_gate_supply_fault_i,
	input wire logic pump_undervolt_two_i,
	input wire logic pump_overvolt_flag_i,
	input wire logic pump_overvolt_absolute_flag_i,
	input wire logic gate_fault_high_a_i,
	input wire logic gate_fault_low_a_i,
	input wire logic gate_fault_high_b_i,
	input wire logic gate_fault_low_b_i,
	input wire logic gate_fault_high_c_i,
	input wire logic gate_fault_low_c_i,
	input wire logic fault_clear_command_i,
	input wire logic gate_enable_reset_i,
	input wire logic sleep_entry_i,
	output var logic [1:0] high_drive_time_o,
	output var logic [3:0] high_sink_current_o,
	output var logic [3:0] high_source_current_o,
	output var logic [1:0] low_drive_time_o,
	output var logic [3:0] low_sink_current_o,
	output var logic [3:0] low_source_current_o,
	output var gdr_pkg::gdr_word_t device_fault_flags_o,
	output var gdr_pkg::gdr_word_t gate_voltage_fault_flags_o
);
	import gdr_pkg::*;

	// ****************************************************************
	// pin edge detection
	// ****************************************************************
	logic sclk_reg;
	logic cs_n_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
		end else begin
			sclk_reg <= spi_sclk_i;
			cs_n_reg <= spi_cs_n_i;
		end
	end

	assign sclk_rise = spi_sclk_i & ~sclk_reg;
	assign sclk_fall = ~spi_sclk_i & sclk_reg;
	assign cs_fall = ~spi_cs_n_i & cs_n_reg;
	assign cs_rise = spi_cs_n_i & ~cs_n_reg;

	// ****************************************************************
	// frame state
	// ****************************************************************
	gdr_spi_state_t state_reg;
	gdr_spi_state_t state_next;
	gdr_count_t count_reg;
	gdr_count_t count_next;
	logic [15:0] rx_reg;
	logic [15:0] rx_next;
	logic sample_bit;
	logic last_bit_in;

	assign sample_bit = sclk_fall & ~spi_cs_n_i;
	assign last_bit_in = count_reg == `GDR_FRAME_BITS;

	// a frame longer or shorter than 16 clocks is dropped whole
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			GDR_ST_IDLE: begin
				if (cs_fall) begin
					state_next = GDR_ST_SHIFT;
				end
			end
			GDR_ST_SHIFT: begin
				if (spi_cs_n_i) begin
					state_next = GDR_ST_IDLE;
				end else if (sample_bit && last_bit_in) begin
					state_next = GDR_ST_ERROR;
				end
			end
			GDR_ST_ERROR: begin
				if (spi_cs_n_i) begin
					state_next = GDR_ST_IDLE;
				end
			end
			default: begin
				state_next = GDR_ST_IDLE;
			end
		endcase
	end

	assign count_next = (state_reg == GDR_ST_IDLE) ? 5'd0 :
		(sample_bit && !last_bit_in) ? count_reg + 5'd1 : count_reg;
	assign rx_next = (state_reg == GDR_ST_SHIFT && sample_bit) ?
		{rx_reg[14:0], spi_mosi_i} : rx_reg;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= GDR_ST_IDLE;
			count_reg <= 5'd0;
			rx_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			rx_reg <= rx_next;
		end
	end

	// ****************************************************************
	// frame fields
	// ****************************************************************
	logic addr_ready;
	gdr_addr_t early_addr;
	logic frame_done;
	logic frame_read;
	gdr_addr_t frame_addr;
	gdr_word_t frame_data;

	// address is complete on the fifth sampled bit
	assign addr_ready = state_reg == GDR_ST_SHIFT && sample_bit &&
		count_reg == `GDR_ADDR_DONE_BITS;
	assign early_addr = {rx_reg[2:0], spi_mosi_i};
	assign frame_done = cs_rise && state_reg == GDR_ST_SHIFT &&
		last_bit_in;
	assign frame_read = rx_reg[`GDR_RW_BIT];
	assign frame_addr = rx_reg[`GDR_ADDR_MSB:`GDR_ADDR_LSB];
	assign frame_data = rx_reg[`GDR_DATA_MSB:0];

	// ****************************************************************
	// register words
	// ****************************************************************
	gdr_word_t device_raw;
	gdr_word_t gate_raw;
	gdr_word_t device_flags;
	gdr_word_t gate_flags;
	logic flag_clear;
	logic high_hit;
	logic low_hit;

	assign device_raw = {
		power_supply_undervolt_two_i,
		watchdog_expired_flag_i,
		overtemp_shutdown_flag_i,
		1'b0,
		regulator_undervolt_flag_i,
		analog_supply_undervolt_flag_i,
		low_gate_supply_fault_i,
		1'b0,
		pump_undervolt_two_i,
		pump_overvolt_flag_i,
		pump_overvolt_absolute_flag_i
	};
	assign gate_raw = {
		gate_fault_high_a_i,
		gate_fault_low_a_i,
		gate_fault_high_b_i,
		gate_fault_low_b_i,
		gate_fault_high_c_i,
		gate_fault_low_c_i,
		5'h00
	};

	// only status words respond to the clear; control words ignore it
	assign flag_clear = fault_clear_command_i | gate_enable_reset_i;

	gdr_flag_word #(
		.VALID_MASK(`GDR_DEVICE_FAULT_MASK)
	) u_device_flags (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.raw_i(device_raw),
		.clear_i(flag_clear),
		.flags_o(device_flags)
	);

	gdr_flag_word #(
		.VALID_MASK(`GDR_GATE_FAULT_MASK)
	) u_gate_flags (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.raw_i(gate_raw),
		.clear_i(flag_clear),
		.flags_o(gate_flags)
	);

	gdr_word_if high_bus ();
	gdr_word_if low_bus ();

	// writes only on a complete frame; status addresses have no write
	assign high_hit = frame_addr == `GDR_ADDR_HIGH_DRIVE;
	assign low_hit = frame_addr == `GDR_ADDR_LOW_DRIVE;
	assign high_bus.wr_en = frame_done && !frame_read && high_hit;
	assign low_bus.wr_en = frame_done && !frame_read && low_hit;
	assign high_bus.wr_data = frame_data;
	assign low_bus.wr_data = frame_data;

	gdr_drive_word u_high_word (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.restore_i(sleep_entry_i),
		.bus(high_bus.word),
		.time_o(high_drive_time_o),
		.sink_o(high_sink_current_o),
		.source_o(high_source_current_o)
	);

	gdr_drive_word u_low_word (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.restore_i(sleep_entry_i),
		.bus(low_bus.word),
		.time_o(low_drive_time_o),
		.sink_o(low_sink_current_o),
		.source_o(low_source_current_o)
	);

	assign device_fault_flags_o = device_flags;
	assign gate_voltage_fault_flags_o = gate_flags;

	// ****************************************************************
	// reply path
	// ****************************************************************
	gdr_word_t read_mux;
	gdr_word_t resp_reg;
	gdr_count_t out_index;
	logic out_in_data;
	logic miso_next;
	logic miso_reg;
	logic miso_en_n_reg;

	// unmapped addresses answer zero
	assign read_mux =
		(early_addr == `GDR_ADDR_DEVICE_FAULT) ? device_flags :
		(early_addr == `GDR_ADDR_GATE_FAULT) ? gate_flags :
		(early_addr == `GDR_ADDR_HIGH_DRIVE) ? high_bus.rd_data :
		(early_addr == `GDR_ADDR_LOW_DRIVE) ? low_bus.rd_data :
		`GDR_STATUS_RESET;

	// snapshot taken before the write commits at frame end
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			resp_reg <= `GDR_STATUS_RESET;
		end else if (addr_ready) begin
			resp_reg <= read_mux;
		end
	end

	// bit shifted out on rising edge n+1 is word bit 15 - n
	assign out_index = `GDR_TOP_BIT - count_reg;
	assign out_in_data = count_reg > 5'd4 && !last_bit_in;
	assign miso_next = out_in_data ? resp_reg[out_index[3:0]] : 1'b0;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			miso_reg <= 1'b0;
			miso_en_n_reg <= 1'b1;
		end else begin
			miso_en_n_reg <= spi_cs_n_i;
			if (spi_cs_n_i) begin
				miso_reg <= 1'b0;
			end else if (sclk_rise && state_reg == GDR_ST_SHIFT) begin
				miso_reg <= miso_next;
			end
		end
	end

	assign spi_miso_o = miso_reg;
	assign spi_miso_en_n_o = miso_en_n_reg;
endmodule : gdr_bank_top

`default_nettype wire

// file: hw/gdr_defines.svh
/*
 * Offsets, field positions, reset values and frame sizes of the
 * gate driver fault and drive register bank.
 * Assumes it is included by bare name and only defines macros.
 */
`ifndef GDR_DEFINES_SVH
`define GDR_DEFINES_SVH

// ****************************************************************
// serial frame layout
// ****************************************************************
`define GDR_FRAME_BITS 5'd16
`define GDR_ADDR_DONE_BITS 5'd4
`define GDR_RW_BIT 15
`define GDR_ADDR_MSB 14
`define GDR_ADDR_LSB 11
`define GDR_DATA_MSB 10
`define GDR_TOP_BIT 5'd15

// ****************************************************************
// word addresses
// ****************************************************************
`define GDR_ADDR_DEVICE_FAULT 4'h3
`define GDR_ADDR_GATE_FAULT 4'h4
`define GDR_ADDR_HIGH_DRIVE 4'h5
`define GDR_ADDR_LOW_DRIVE 4'h6

// ****************************************************************
// status words
// ****************************************************************
`define GDR_DEVICE_FAULT_MASK 11'h777
`define GDR_GATE_FAULT_MASK 11'h7e0
`define GDR_STATUS_RESET 11'h000

// ****************************************************************
// drive words
// ****************************************************************
`define GDR_TIME_MSB 9
`define GDR_TIME_LSB 8
`define GDR_SINK_MSB 7
`define GDR_SINK_LSB 4
`define GDR_SOURCE_MSB 3
`define GDR_SOURCE_LSB 0
`define GDR_TIME_RESET 2'h3
`define GDR_SINK_RESET 4'h4
`define GDR_SOURCE_RESET 4'h4
`define GDR_SINK_MAX_CODE 4'ha
`define GDR_SOURCE_ALIAS_CODE 4'he
`define GDR_CURRENT_FALLBACK 4'h4

`endif

// file: hw/gdr_pkg.sv
/*
 * Types shared by the gate driver register bank modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package gdr_pkg;
	typedef logic [10:0] gdr_word_t;
	typedef logic [3:0] gdr_addr_t;
	typedef logic [4:0] gdr_count_t;
	typedef enum logic [2:0] {
		GDR_ST_IDLE = 3'b001,
		GDR_ST_SHIFT = 3'b010,
		GDR_ST_ERROR = 3'b100
	} gdr_spi_state_t;
endpackage : gdr_pkg

`default_nettype wire

// file: hw/gdr_word_if.sv
/*
 * Write and readback path between the bank and a control word.
 * Assumes one bank drives each instance.
 */
`default_nettype none

interface gdr_word_if;
	import gdr_pkg::*;
	logic wr_en;
	gdr_word_t wr_data;
	gdr_word_t rd_data;
	modport bank (output wr_en, output wr_data, input rd_data);
	modport word (input wr_en, input wr_data, output rd_data);
endinterface : gdr_word_if

`default_nettype wire

// file: hw/gdr_flag_word.sv
/*
 * Sticky read-only fault word with a mask of implemented bits.
 * Assumes raw fault levels are synchronous to the clock.
 */
`default_nettype none
`include "gdr_defines.svh"

module gdr_flag_word #(
	parameter logic [10:0] VALID_MASK = 11'h7ff
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire gdr_pkg::gdr_word_t raw_i,
	input wire logic clear_i,
	output var gdr_pkg::gdr_word_t flags_o
);
	import gdr_pkg::*;

	gdr_word_t flags_reg;
	gdr_word_t flags_next;
	gdr_word_t kept;

	// a fault arriving with the clear still lands
	assign kept = clear_i ? `GDR_STATUS_RESET : flags_reg;
	assign flags_next = (kept | raw_i) & VALID_MASK;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flags_reg <= `GDR_STATUS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_o = flags_reg;
endmodule : gdr_flag_word

`default_nettype wire

// file: hw/gdr_drive_word.sv
/*
 * One gate drive setup word: time, sink and source current codes.
 * Assumes the bank pulses wr_en once per accepted write frame.
 */
`default_nettype none
`include "gdr_defines.svh"

module gdr_drive_word (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic restore_i,
	gdr_word_if.word bus,
	output var logic [1:0] time_o,
	output var logic [3:0] sink_o,
	output var logic [3:0] source_o
);
	import gdr_pkg::*;

	logic [1:0] time_reg;
	logic [3:0] sink_reg;
	logic [3:0] source_reg;
	logic sink_alias;
	logic source_alias;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			time_reg <= `GDR_TIME_RESET;
			sink_reg <= `GDR_SINK_RESET;
			source_reg <= `GDR_SOURCE_RESET;
		end else if (restore_i) begin
			time_reg <= `GDR_TIME_RESET;
			sink_reg <= `GDR_SINK_RESET;
			source_reg <= `GDR_SOURCE_RESET;
		end else if (bus.wr_en) begin
			time_reg <= bus.wr_data[`GDR_TIME_MSB:`GDR_TIME_LSB];
			sink_reg <= bus.wr_data[`GDR_SINK_MSB:`GDR_SINK_LSB];
			source_reg <= bus.wr_data[`GDR_SOURCE_MSB:`GDR_SOURCE_LSB];
		end
	end

	// readback is the raw code; the analog side sees the effective one
	assign bus.rd_data = {1'b0, time_reg, sink_reg, source_reg};
	assign sink_alias = sink_reg > `GDR_SINK_MAX_CODE;
	assign source_alias = source_reg >= `GDR_SOURCE_ALIAS_CODE;
	assign time_o = time_reg;
	assign sink_o = sink_alias ? `GDR_CURRENT_FALLBACK : sink_reg;
	assign source_o = source_alias ? `GDR_CURRENT_FALLBACK : source_reg;
endmodule : gdr_drive_word

`default_nettype wire

// file: tb/gdr_bank_assertions.sv
/*
 * Pin-level checker for the gate driver register bank.
 * Assumes a bind from the bench onto gdr_bank_top.
 */
`default_nettype none

module gdr_bank_assertions (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_miso_o,
	input wire logic spi_miso_en_n_o,
	input wire logic watchdog_expired_flag_i,
	input wire logic pump_overvolt_absolute_flag_i,
	input wire logic gate_fault_high_a_i,
	input wire logic fault_clear_command_i,
	input wire logic gate_enable_reset_i,
	input wire logic sleep_entry_i,
	input wire logic [1:0] high_drive_time_o,
	input wire logic [3:0] high_sink_current_o,
	input wire logic [3:0] high_source_current_o,
	input wire logic [1:0] low_drive_time_o,
	input wire logic [3:0] low_sink_current_o,
	input wire logic [3:0] low_source_current_o,
	input wire gdr_pkg::gdr_word_t device_fault_flags_o,
	input wire gdr_pkg::gdr_word_t gate_voltage_fault_flags_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import gdr_pkg::*;
	// time 3, sink 4, source 4 on both sides
	localparam logic [19:0] DRV_DEF = 20'hd1344;
	wire logic [19:0] drv = {high_drive_time_o, high_sink_current_o,
		high_source_current_o, low_drive_time_o, low_sink_current_o,
		low_source_current_o};
	wire logic no_cs = spi_cs_n_i;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	property p_idle;
		no_cs && $past(no_cs) |-> spi_miso_en_n_o && !spi_miso_o;
	endproperty
	property p_drive;
		!no_cs && !$past(no_cs) |-> !spi_miso_en_n_o;
	endproperty
	property p_rsvd_dev;
		(device_fault_flags_o & 11'h088) == 11'h000;
	endproperty
	property p_rsvd_gate;
		(gate_voltage_fault_flags_o & 11'h01f) == 11'h000;
	endproperty
	property p_wd_set;
		watchdog_expired_flag_i |=> device_fault_flags_o[9];
	endproperty
	property p_abs_set;
		pump_overvolt_absolute_flag_i |=> device_fault_flags_o[0];
	endproperty
	property p_ha_set;
		gate_fault_high_a_i |=> gate_voltage_fault_flags_o[10];
	endproperty
	property p_sleep;
		sleep_entry_i |=> drv == DRV_DEF;
	endproperty
	property p_boot;
		$rose(reset_n_i) |-> drv == DRV_DEF;
	endproperty
	// no frame can land: select high for two samples
	property p_keep;
		(fault_clear_command_i || gate_enable_reset_i) && no_cs
			&& $past(no_cs) && !sleep_entry_i |=> $stable(drv);
	endproperty
	property p_sink_lim;
		high_sink_current_o <= 4'ha && low_sink_current_o <= 4'ha;
	endproperty
	property p_src_lim;
		high_source_current_o < 4'he && low_source_current_o < 4'he;
	endproperty

	a_idle: assert property (p_idle)
		else $error("miso active while deselected");
	a_drive: assert property (p_drive)
		else $error("miso not driven while selected");
	a_rsvd_dev: assert property (p_rsvd_dev)
		else $error("device word reserved bit set");
	a_rsvd_gate: assert property (p_rsvd_gate)
		else $error("gate word reserved bit set");
	a_wd_set: assert property (p_wd_set)
		else $error("watchdog flag not latched");
	a_abs_set: assert property (p_abs_set)
		else $error("absolute pump flag not latched");
	a_ha_set: assert property (p_ha_set)
		else $error("gate high a flag not latched");
	a_sleep: assert property (p_sleep)
		else $error("sleep did not restore drive");
	a_boot: assert property (p_boot)
		else $error("drive not default after reset");
	a_keep: assert property (p_keep)
		else $error("fault clear moved drive words");
	a_sink_lim: assert property (p_sink_lim)
		else $error("sink code above top code");
	a_src_lim: assert property (p_src_lim)
		else $error("source alias code passed");

	c_sleep: cover property (sleep_entry_i);
	c_frame: cover property ($fell(spi_cs_n_i));
	c_clear: cover property (fault_clear_command_i);
endmodule : gdr_bank_assertions

`default_nettype wire

// file: tb/gdr_spi_host.sv
/*
 * Behavioural serial host: clock idles low, bit out with each rise.
 * Assumes the bench clock is sys_clk_i and frames never overlap.
 */
`default_nettype none

module gdr_spi_host (
	input wire logic sys_clk_i,
	output logic spi_sclk_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o,
	input wire logic spi_miso_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// six cycles leaves margin over the four-cycle minimum
	localparam int HALF = 6;

	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end

	// n other than 16 makes a frame error on purpose
	task automatic xfer(input logic [15:0] tx, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge sys_clk_i);
		spi_cs_n_o <= 1'b0;
		repeat (HALF) @(posedge sys_clk_i);
		// data moves with the rise so it stays steady across the fall
		for (int i = 0; i < n; i++) begin
			spi_sclk_o <= 1'b1;
			spi_mosi_o <= (i < 16) ? tx[15 - i] : 1'b0;
			repeat (HALF) @(posedge sys_clk_i);
			if (i < 16) begin
				rx[15 - i] = spi_miso_i;
			end
			spi_sclk_o <= 1'b0;
			repeat (HALF) @(posedge sys_clk_i);
		end
		repeat (HALF) @(posedge sys_clk_i);
		spi_cs_n_o <= 1'b1;
		// released line must not keep its last bit
		spi_mosi_o <= ~spi_mosi_o;
		repeat (HALF) @(posedge sys_clk_i);
	endtask : xfer
endmodule : gdr_spi_host

`default_nettype wire

// file: tb/tb_top.sv
/*
 * Self-checking bench for the register bank over the serial link.
 * Assumes gdr_pkg, the checker and the host model are compiled first.
 */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import gdr_pkg::*;
	logic clk, rst_n, sclk, cs_n, mosi, miso, miso_en_n, clr, ger, slp;
	logic [10:0] dev_raw, gate_raw;
	logic [1:0] ht, lt;
	logic [3:0] hk, hs, lk, ls;
	gdr_word_t dev_f, gate_f, w;
	logic [15:0] rx;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;

	gdr_bank_top u_gdr_bank_top (
		.sys_clk_i(clk), .reset_n_i(rst_n), .spi_sclk_i(sclk),
		.spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
		.spi_miso_en_n_o(miso_en_n),
		.power_supply_undervolt_two_i(dev_raw[10]),
		.watchdog_expired_flag_i(dev_raw[9]),
		.overtemp_shutdown_flag_i(dev_raw[8]),
		.regulator_undervolt_flag_i(dev_raw[6]),
		.analog_supply_undervolt_flag_i(dev_raw[5]),
		.low_gate_supply_fault_i(dev_raw[4]),
		.pump_undervolt_two_i(dev_raw[2]),
		.pump_overvolt_flag_i(dev_raw[1]),
		.pump_overvolt_absolute_flag_i(dev_raw[0]),
		.gate_fault_high_a_i(gate_raw[10]), .gate_fault_low_a_i(gate_raw[9]),
		.gate_fault_high_b_i(gate_raw[8]), .gate_fault_low_b_i(gate_raw[7]),
		.gate_fault_high_c_i(gate_raw[6]), .gate_fault_low_c_i(gate_raw[5]),
		.fault_clear_command_i(clr), .gate_enable_reset_i(ger),
		.sleep_entry_i(slp), .high_drive_time_o(ht),
		.high_sink_current_o(hk), .high_source_current_o(hs),
		.low_drive_time_o(lt), .low_sink_current_o(lk),
		.low_source_current_o(ls), .device_fault_flags_o(dev_f),
		.gate_voltage_fault_flags_o(gate_f)
	);
	gdr_spi_host u_gdr_spi_host (.sys_clk_i(clk), .spi_sclk_o(sclk),
		.spi_cs_n_o(cs_n), .spi_mosi_o(mosi), .spi_miso_i(miso));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// a frame is about 210 cycles; the run needs under 10000
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	task chk_w(input string nm, input logic [10:0] e, input logic [10:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_w
	task chk_c(input string nm, input logic [3:0] e, input logic [3:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_c
	task rd(input gdr_addr_t a, output gdr_word_t d);
		u_gdr_spi_host.xfer({1'b1, a, 11'h000}, 16, rx);
		d = rx[10:0];
	endtask : rd
	task wr(input gdr_addr_t a, input gdr_word_t d);
		u_gdr_spi_host.xfer({1'b0, a, d}, 16, rx);
	endtask : wr
	task pulse(input int which);
		@(posedge clk);
		clr <= (which == 0);
		ger <= (which == 1);
		slp <= (which == 2);
		@(posedge clk);
		{clr, ger, slp} <= 3'b000;
	endtask : pulse

	// ********
	// scenarios
	// ********
	task t_defaults;
		rd(4'h5, w);
		chk_w("high word", 11'h344, w);
		rd(4'h6, w);
		chk_w("low word", 11'h344, w);
		rd(4'h3, w);
		chk_w("device flags", 11'h000, w);
	endtask : t_defaults
	task t_write;
		wr(4'h5, 11'h7a5);
		chk_w("prior high", 11'h344, rx[10:0]);
		rd(4'h5, w);
		chk_w("high readback", 11'h3a5, w);
		chk_c("high sink", 4'ha, hk);
		chk_c("high source", 4'h5, hs);
		wr(4'h6, 11'h2fe);
		rd(4'h6, w);
		chk_w("low readback", 11'h2fe, w);
		chk_c("low time", 4'h2, {2'b00, lt});
		chk_c("low sink", 4'h4, lk);
		chk_c("low source", 4'h4, ls);
		wr(4'h5, 11'h0bf);
		chk_c("high time", 4'h0, {2'b00, ht});
		chk_c("sink alias", 4'h4, hk);
		chk_c("source alias", 4'h4, hs);
	endtask : t_write
	task t_keep;
		pulse(0);
		pulse(1);
		rd(4'h5, w);
		rd(4'h5, w);
		chk_w("kept high", 11'h0bf, w);
		u_gdr_spi_host.xfer({1'b0, 4'h6, 11'h155}, 15, rx);
		rd(4'h6, w);
		chk_w("short frame", 11'h2fe, w);
		u_gdr_spi_host.xfer({1'b0, 4'h6, 11'h155}, 17, rx);
		rd(4'h6, w);
		chk_w("long frame", 11'h2fe, w);
	endtask : t_keep
	task t_flags;
		for (int i = 0; i < 11; i++) begin
			pulse(0);
			dev_raw <= 11'h001 << i;
			gate_raw <= 11'h001 << i;
			@(posedge clk);
			dev_raw <= 11'h000;
			gate_raw <= 11'h000;
			rd(4'h3, w);
			chk_w("device bit", (11'h001 << i) & 11'h777, w);
			rd(4'h4, w);
			chk_w("gate bit", (11'h001 << i) & 11'h7e0, w);
			chk_w("device out", (11'h001 << i) & 11'h777, dev_f);
			chk_w("gate out", (11'h001 << i) & 11'h7e0, gate_f);
		end
		wr(4'h3, 11'h000);
		wr(4'h4, 11'h000);
		rd(4'h3, w);
		chk_w("device write", 11'h400, w);
		rd(4'h4, w);
		chk_w("gate write", 11'h400, w);
	endtask : t_flags
	task t_sleep;
		pulse(2);
		rd(4'h5, w);
		chk_w("high after sleep", 11'h344, w);
		rd(4'h6, w);
		chk_w("low after sleep", 11'h344, w);
	endtask : t_sleep

	task finish_test;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	initial begin
		rst_n = 1'b0;
		{clr, ger, slp} = 3'b000;
		dev_raw = 11'h000;
		gate_raw = 11'h000;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_defaults();
		t_write();
		t_keep();
		t_flags();
		t_sleep();
		finish_test();
	end
endmodule : tb_top

bind gdr_bank_top gdr_bank_assertions u_gdr_bank_assertions (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(spi_cs_n_i),
	.spi_miso_o(spi_miso_o), .spi_miso_en_n_o(spi_miso_en_n_o),
	.watchdog_expired_flag_i(watchdog_expired_flag_i),
	.pump_overvolt_absolute_flag_i(pump_overvolt_absolute_flag_i),
	.gate_fault_high_a_i(gate_fault_high_a_i),
	.fault_clear_command_i(fault_clear_command_i),
	.gate_enable_reset_i(gate_enable_reset_i),
	.sleep_entry_i(sleep_entry_i), .high_drive_time_o(high_drive_time_o),
	.high_sink_current_o(high_sink_current_o),
	.high_source_current_o(high_source_current_o),
	.low_drive_time_o(low_drive_time_o),
	.low_sink_current_o(low_sink_current_o),
	.low_source_current_o(low_source_current_o),
	.device_fault_flags_o(device_fault_flags_o),
	.gate_voltage_fault_flags_o(gate_voltage_fault_flags_o)
);

`default_nettype wire
